// file: sim/oms_host.sv
`timescale 1ns/1ps
// Host on the register port; one-cycle strobes
module oms_host (
  input wire clk,
  output reg [7:0] addr,
  output reg [7:0] wdata,
  output reg wr,
  output reg rd
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Data is inverted on release so stale values never match
  task w(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
    end
  endtask
  // Polling read; the bench monitor takes the data
  task r(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
    end
  endtask
endmodule // oms_host

// file: sim/oms_status_asserts.sv
`timescale 1ns/1ps
// Port checks for the mode and hold status block
module oms_status_asserts (
  input wire SYS_CLK,
  input wire RESETN,
  input wire SOFT_RESET,
  input wire BOOT_CONFIG_PIN,
  input wire MOTION_DETECT_SELECT,
  input wire RD,
  input wire [7:0] ADDR,
  input wire [7:0] RDATA,
  input wire [1:0] OPERATING_STATE_FIELD,
  input wire IRQ_PIN_ONE_OE,
  input wire IRQ_PIN_TWO_OE,
  input wire DEBOUNCE_RESET
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Reads see the mode held at the strobe edge
  a_mode_read: assert property (
    $past(RD) && $past(ADDR) == 8'h14
    |-> RDATA[1:0] == $past(OPERATING_STATE_FIELD)) else $error("mode");
  a_soft_standby: assert property (
    $fell(SOFT_RESET) && !BOOT_CONFIG_PIN
    |-> ##[0:3] OPERATING_STATE_FIELD == 2'h0) else $error("standby");
  a_soft_wake: assert property (
    $fell(SOFT_RESET) && BOOT_CONFIG_PIN && MOTION_DETECT_SELECT
    |-> ##[0:3] OPERATING_STATE_FIELD == 2'h1) else $error("wake");
  a_no_trig_boot: assert property (
    BOOT_CONFIG_PIN [*8] |-> OPERATING_STATE_FIELD != 2'h3)
    else $error("trig");
  // Pins are released by the second cycle out of wake
  a_wake_pins: assert property (
    (OPERATING_STATE_FIELD != 2'h1) [*2]
    |-> !IRQ_PIN_ONE_OE && !IRQ_PIN_TWO_OE) else $error("pin");
  a_entry_debounce: assert property (
    $changed(OPERATING_STATE_FIELD) && OPERATING_STATE_FIELD != 2'h0
    |-> ##[0:1] DEBOUNCE_RESET) else $error("debounce");
  a_debounce_pulse: assert property (
    DEBOUNCE_RESET |=> !DEBOUNCE_RESET) else $error("pulse");
  a_count_idle: assert property (
    $past(RD) && $past(ADDR) == 8'h14 && !RDATA[7]
    |-> RDATA[6:2] == 5'h00) else $error("count");
endmodule // oms_status_asserts

bind oms_status oms_status_asserts u_oms_status_asserts (.SYS_CLK, .RESETN,
  .SOFT_RESET, .BOOT_CONFIG_PIN, .MOTION_DETECT_SELECT, .RD, .ADDR, .RDATA,
  .OPERATING_STATE_FIELD, .IRQ_PIN_ONE_OE, .IRQ_PIN_TWO_OE, .DEBOUNCE_RESET);

// file: sim/tb.sv
`timescale 1ns/1ps
// Bench: reads queue expectations, monitor compares
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg boot = 1'b0;
  reg mot = 1'b0;
  reg [5:0] ev = 6'h00;
  reg [5:0] fill = 6'h01;
  reg [1:0] bop = 2'h1;
  reg rd_d = 1'b0;
  reg [31:0] rnd;
  integer seed = 43;
  integer n_mismatch = 0;
  integer check_count = 0;
  integer k;
  reg [7:0] exp_q[$];
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, p1o, p1e, p2o, p2e, dbr, irq;
  wire [1:0] mode;
  always #2.5 clk = ~clk;
  oms_host u_oms_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  oms_status u_oms_status (.SYS_CLK(clk), .RESETN(rst_n), .SOFT_RESET(ev[5]),
    .BOOT_CONFIG_PIN(boot), .MOTION_DETECT_SELECT(mot), .TRIGGER_IN(ev[4]),
    .MEAS_DONE(ev[3]), .SAMPLE_READY(ev[2]), .PERIOD_TICK(ev[1]),
    .BUF_FILL_COUNT(fill), .BUF_FLUSH(ev[0]), .BUF_OPERATION(bop),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .OPERATING_STATE_FIELD(mode), .IRQ_PIN_ONE_O(p1o), .IRQ_PIN_ONE_OE(p1e),
    .IRQ_PIN_TWO_O(p2o), .IRQ_PIN_TWO_OE(p2e), .DEBOUNCE_RESET(dbr),
    .IRQ(irq));
  // Compare helpers and stimulus tasks
  task chk(input [8*5-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rx(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      u_oms_host.r(a);
    end
  endtask
  task w(input [7:0] a, input [7:0] d);
    begin
      u_oms_host.w(a, d);
      repeat (3) @(posedge clk);
    end
  endtask
  task pul(input [5:0] v);
    begin
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 6'h00;
      repeat (3) @(posedge clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d)
      chk("rdata", exp_q.pop_front(), rdata);
    rd_d <= rd;
  end
  // Sequence takes well under a thousand cycles
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  // Main sequence: modes, interrupt, pins, hold error, boot
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rx(8'h14, 8'h00);
    w(8'h14, 8'hFF);
    rx(8'h14, 8'h00);
    w(8'h42, 8'hFF);
    w(8'h40, 8'h01);
    rx(8'h14, 8'h01);
    rx(8'h41, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    w(8'h41, 8'h01);
    rx(8'h41, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    w(8'h40, 8'h03);
    rx(8'h14, 8'h02);
    w(8'h40, 8'h07);
    rx(8'h14, 8'h03);
    pul(6'h10);
    rx(8'h14, 8'h01);
    pul(6'h08);
    rx(8'h14, 8'h03);
    w(8'h40, 8'h29);
    chk("pin", 8'h07, {4'h0, p2e, p2o, p1e, p1o});
    w(8'h40, 8'h19);
    chk("pin", 8'h08, {4'h0, p2e, p2o, p1e, p1o});
    $display("modes done");
    // Each pass clears the error a different way
    for (k = 0; k < 4; k = k + 1) begin
      w(8'h40, 8'h41);
      rnd = $random(seed);
      fill <= 6'h01 | rnd[5:0];
      bop <= 2'h1;
      pul(6'h04);
      repeat (k + 1) pul(6'h02);
      rx(8'h14, {1'b1, 5'(k + 1), 2'h1});
      case (k)
        0: pul(6'h01);
        1: bop <= 2'h0;
        2: fill <= 6'h00;
        default: w(8'h40, 8'h40);
      endcase
      w(8'h40, 8'h41);
      rx(8'h14, 8'h01);
    end
    rx(8'h41, 8'h03);
    $display("hold done");
    boot <= 1'b1;
    mot <= 1'b1;
    pul(6'h20);
    rx(8'h14, 8'h01);
    w(8'h40, 8'h05);
    rx(8'h14, 8'h01);
    boot <= 1'b0;
    pul(6'h20);
    rx(8'h14, 8'h00);
    repeat (4) @(posedge clk);
    $display("boot done");
    report_and_stop;
  end
endmodule // tb

// file: verilog/oms_map.vh
`ifndef OMS_MAP_VH
`define OMS_MAP_VH

// Register offsets
`define OMS_ADDR_STATUS 8'h14
`define OMS_ADDR_CTRL 8'h40
`define OMS_ADDR_IRQ_STAT 8'h41
`define OMS_ADDR_IRQ_MASK 8'h42

// Status register fields
`define OMS_ERR_BIT 7
`define OMS_CNT_LSB 2
`define OMS_CNT_MSB 6

// Mode codes
`define OMS_MODE_STANDBY 2'h0
`define OMS_MODE_WAKE 2'h1
`define OMS_MODE_SLEEP 2'h2
`define OMS_MODE_TRIG 2'h3

// Control register fields
`define OMS_CTL_ACTIVE 0
`define OMS_CTL_SLEEP 1
`define OMS_CTL_TRIG_EN 2
`define OMS_CTL_WAKE_OUT_EN 3
`define OMS_CTL_WAKE_PIN2 4
`define OMS_CTL_POL 5
`define OMS_CTL_HOLD 6
`define OMS_CTL_RESET 8'h00

// Interrupt status bits
`define OMS_IRQ_MODE 0
`define OMS_IRQ_ERR 1
`define OMS_IRQ_RESET 8'h00

// Buffer operation field code that disables the buffer
`define OMS_BUF_OFF 2'h0
`endif

// file: verilog/oms_sat_counter.v
`timescale 1ns/1ps
// Saturating period counter, cleared on demand
module oms_sat_counter #(
  parameter WIDTH = 5
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire step,
  output reg [WIDTH-1:0] count
);
  // Saturate so a long-stuck error does not wrap to a small count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
    end else if (step && (count != {WIDTH{1'b1}})) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // oms_sat_counter

// file: verilog/oms_status.v
`timescale 1ns/1ps
`include "oms_map.vh"
// Operating mode and buffer hold status block
module oms_status #(
  parameter CNT_W = 5
) (
  input wire SYS_CLK,
  input wire RESETN,
  input wire SOFT_RESET,
  input wire BOOT_CONFIG_PIN,
  input wire MOTION_DETECT_SELECT,
  input wire TRIGGER_IN,
  input wire MEAS_DONE,
  input wire SAMPLE_READY,
  input wire PERIOD_TICK,
  input wire [5:0] BUF_FILL_COUNT,
  input wire BUF_FLUSH,
  input wire [1:0] BUF_OPERATION,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  output wire [1:0] OPERATING_STATE_FIELD,
  output reg IRQ_PIN_ONE_O,
  output reg IRQ_PIN_ONE_OE,
  output reg IRQ_PIN_TWO_O,
  output reg IRQ_PIN_TWO_OE,
  output reg DEBOUNCE_RESET,
  output wire IRQ
);
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg boot_pending_r;
  reg boot_high_r;
  reg [7:0] ctrl_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg err_r;
  reg err_nxt;
  wire [CNT_W-1:0] gate_cnt;
  wire err_clear;
  wire standby_exit;
  wire mode_change;
  wire err_rise;
  wire trig_allowed;

  // Overview of the block
  // The mode field reports standby, wake, sleep or trigger wait.
  // The status register is read only; a write to it is dropped.
  // Control, interrupt status and mask sit beside it on the port.
  // Control bit 0 makes the block active, else it rests in standby.
  // Control bit 1 picks sleep over wake while active.
  // Control bit 2 turns on the trigger loop while active.
  // Control bit 3 turns on the wake indicator output.
  // Control bit 4 moves the wake indicator to pin two.
  // Control bit 5 sets the level the wake indicator drives.
  // Control bit 6 turns on buffer hold, which can raise the error.
  //
  // Boot handling
  // The strap is sampled once, one edge after reset or soft reset.
  // Sampling once keeps a bouncing strap from moving the mode.
  // Limitation: a strap change without a reset is not seen.
  // A soft reset reloads the control defaults before the strap.
  // With strap and motion select high the block boots active.
  // That keeps the block in wake after boot instead of falling back.
  //
  // Trigger loop
  // While enabled the block waits in the trigger state.
  // A trigger moves it to wake for the measurement.
  // The end of the measurement sends it back to wait.
  // A latched high strap locks the loop out entirely.
  // Trade-off: entering from wake waits for a measurement end.
  // That avoids cutting a measurement that is already running.
  //
  // Debounce reset
  // A single pulse marks every entry into a non-standby state.
  // The pulse lines up with the cycle the new mode is shown.
  // Detectors outside the block clear their counters on it.
  // Two entries on back to back edges give two pulses in a row.
  //
  // Hold error
  // The error rises on a sample while hold is on and not cleared.
  // Every clear condition but leaving standby is a level, not an edge.
  // An empty buffer or buffer off therefore keeps the flag low.
  // Hazard: a clear and a sample in one cycle leave it low.
  // That is intended, since a clear means the buffer is empty.
  // Leaving standby clears it, as the buffer restarts then.
  //
  // Period count
  // Counts output-data periods only while the error stands.
  // Cleared on the rising error and on every clear condition.
  // Saturates at all ones, so a stuck error never wraps.
  // Software that sees all ones knows it lost track of time.
  //
  // Wake indicator
  // The output enable follows the mode the same cycle it shows.
  // Both data outputs carry the polarity level at all times.
  // Only the selected pin has its enable raised.
  // Limitation: pin select changes take effect on the next edge.
  //
  // Interrupts
  // Status bit 0 flags a mode change, bit 1 a rising error.
  // Writing a one clears a bit; a new event in that cycle wins.
  // The interrupt output is a level from registers only.
  // It stays high until every unmasked bit is cleared.
  //
  // Register port
  // Strobes are one cycle and the block never stalls the host.
  // Read data stand in the cycle after the strobe only.
  // Outside that cycle the read data sit at zero.
  // Unmapped addresses read zero and drop writes.
  // Host software polls the mode field to follow transitions.
  //
  // Reset
  // The asynchronous reset clears every register to a constant.
  // Soft reset reruns the boot step on the next edge.
  // Soft reset leaves the hold error and its count alone.
  // The interrupt status keeps its bits across a soft reset.
  // The mask returns to zero so no stale source fires.

  // Boot strap is latched by a clocked process after reset release
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      boot_pending_r <= 1'b1;
      boot_high_r <= 1'b0;
    end else if (SOFT_RESET) begin
      boot_pending_r <= 1'b1;
    end else if (boot_pending_r) begin
      boot_pending_r <= 1'b0;
      boot_high_r <= BOOT_CONFIG_PIN;
    end
  end

  // Trigger mode is locked out when the boot pin was latched high at boot
  assign trig_allowed = ctrl_r[`OMS_CTL_TRIG_EN] & ~boot_high_r;

  // Next operating state
  always @* begin
    mode_nxt = mode_r;
    if (boot_pending_r) begin
      if (BOOT_CONFIG_PIN && MOTION_DETECT_SELECT) begin
        mode_nxt = `OMS_MODE_WAKE;
      end else begin
        mode_nxt = `OMS_MODE_STANDBY;
      end
    end else if (!ctrl_r[`OMS_CTL_ACTIVE]) begin
      mode_nxt = `OMS_MODE_STANDBY;
    end else if (trig_allowed) begin
      // Wait for trigger, measure in wake, then wait again
      if (mode_r == `OMS_MODE_TRIG) begin
        if (TRIGGER_IN) begin
          mode_nxt = `OMS_MODE_WAKE;
        end
      end else if (mode_r == `OMS_MODE_WAKE) begin
        if (MEAS_DONE) begin
          mode_nxt = `OMS_MODE_TRIG;
        end
      end else begin
        mode_nxt = `OMS_MODE_TRIG;
      end
    end else if (ctrl_r[`OMS_CTL_SLEEP]) begin
      mode_nxt = `OMS_MODE_SLEEP;
    end else begin
      mode_nxt = `OMS_MODE_WAKE;
    end
  end

  // Mode register
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_r <= `OMS_MODE_STANDBY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign OPERATING_STATE_FIELD = mode_r;
  assign mode_change = (mode_nxt != mode_r);
  assign standby_exit = (mode_r == `OMS_MODE_STANDBY) &&
                        (mode_nxt != `OMS_MODE_STANDBY);

  // One-cycle pulse on entry into any active state
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      DEBOUNCE_RESET <= 1'b0;
    end else begin
      DEBOUNCE_RESET <= mode_change &&
                        (mode_nxt != `OMS_MODE_STANDBY);
    end
  end

  // Any of the four clear events; buffer off is held as a level
  assign err_clear = (BUF_FILL_COUNT == 6'h00) || BUF_FLUSH ||
                     (BUF_OPERATION == `OMS_BUF_OFF) ||
                     standby_exit;

  // Hold error flag; the clear events all mean the buffer is
  // emptied, so a clear outranks a simultaneous sample
  always @* begin
    err_nxt = err_r;
    if (err_clear) begin
      err_nxt = 1'b0;
    end else if (ctrl_r[`OMS_CTL_HOLD] && SAMPLE_READY) begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  assign err_rise = err_nxt & ~err_r;

  // Period counter runs only while the error is standing
  oms_sat_counter #(
    .WIDTH(CNT_W)
  ) u_cnt (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .clear(err_clear | err_rise),
    .step(err_r & PERIOD_TICK),
    .count(gate_cnt)
  );

  // Wake indicator: static level on the chosen pin while in wake
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ_PIN_ONE_O <= 1'b0;
      IRQ_PIN_ONE_OE <= 1'b0;
      IRQ_PIN_TWO_O <= 1'b0;
      IRQ_PIN_TWO_OE <= 1'b0;
    end else begin
      IRQ_PIN_ONE_O <= ctrl_r[`OMS_CTL_POL];
      IRQ_PIN_TWO_O <= ctrl_r[`OMS_CTL_POL];
      IRQ_PIN_ONE_OE <= ctrl_r[`OMS_CTL_WAKE_OUT_EN] &&
                        (mode_nxt == `OMS_MODE_WAKE) &&
                        !ctrl_r[`OMS_CTL_WAKE_PIN2];
      IRQ_PIN_TWO_OE <= ctrl_r[`OMS_CTL_WAKE_OUT_EN] &&
                        (mode_nxt == `OMS_MODE_WAKE) &&
                        ctrl_r[`OMS_CTL_WAKE_PIN2];
    end
  end

  // Register writes; the status register takes no write
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= `OMS_CTL_RESET;
      irq_mask_r <= 2'h0;
      irq_stat_r <= 2'h0;
    end else begin
      if (SOFT_RESET) begin
        // Software reset reloads the control defaults
        ctrl_r <= `OMS_CTL_RESET;
        irq_mask_r <= 2'h0;
      end else if (boot_pending_r) begin
        // Strap with motion select boots the block active
        ctrl_r[`OMS_CTL_ACTIVE] <= BOOT_CONFIG_PIN & MOTION_DETECT_SELECT;
      end else if (WR && (ADDR == `OMS_ADDR_CTRL)) begin
        ctrl_r <= WDATA;
      end else if (WR && (ADDR == `OMS_ADDR_IRQ_MASK)) begin
        irq_mask_r <= WDATA[1:0];
      end
      // Set wins over a write-one clear in the same cycle
      if (WR && (ADDR == `OMS_ADDR_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~WDATA[1:0]) |
                      {err_rise, mode_change};
      end else begin
        irq_stat_r <= irq_stat_r | {err_rise, mode_change};
      end
    end
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

  // Read data one cycle after the strobe, zero elsewhere
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      if (ADDR == `OMS_ADDR_STATUS) begin
        RDATA <= {err_r, gate_cnt, mode_r};
      end else if (ADDR == `OMS_ADDR_CTRL) begin
        RDATA <= ctrl_r;
      end else if (ADDR == `OMS_ADDR_IRQ_STAT) begin
        RDATA <= {6'h00, irq_stat_r};
      end else if (ADDR == `OMS_ADDR_IRQ_MASK) begin
        RDATA <= {6'h00, irq_mask_r};
      end else begin
        RDATA <= 8'h00;
      end
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule // oms_status
